// ---- design/motor_speed_loop_and_stall.sv ----
// speed loop gain registers, PI arithmetic and hardware stall detection
// What this block does
// - integral divisor select decodes 32..512,16,1
// - integral gain is numerator over divisor
// - integral gain register resets to 21h
// - stall when sense exceeds reference or 3V
// - blank stall detection after startup
// - stall response chosen by select pin
// - regulate current only when pin enables
// - stall drives fault low, sets status
// - one trip level for stall and regulation
// - proportional gain uses same divisor encoding
`timescale 1ns/1ps
`include "motor_cfg.svh"
module motor_speed_loop_and_stall #(
  parameter int W          = 16,
  parameter int BLANK_UNIT = `BLANK_UNIT_CYC
) (
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  // register port from the serial slave
  input  wire motor_pkg::reg_req_t  i_reg_req,
  output logic [7:0]                o_reg_rdata,
  // comparator results from the analog front end
  input  wire logic                 i_sense_over_ref,
  input  wire logic                 i_sense_over_3v,
  input  wire logic                 i_use_fixed_3v,
  // mode pins
  input  wire logic                 i_stall_response_select_pin,
  input  wire logic                 i_regulation_select_pin,
  // motor control
  input  wire logic                 i_motor_start,
  input  wire logic                 i_ctrl_update,
  input  wire logic signed [W-1:0]  i_speed_error,
  // outputs
  output logic                      o_fault_out_n,
  output logic                      o_bridge_disable,
  output logic                      o_current_chop,
  output logic signed [W+7:0]       o_regulation
);
  // refused at elaboration: the divisor shifts need a few bits, and a zero unit stretches each blanking unit to 2^32 cycles
  if (W < 4) begin : g_bad_width
    $error("W must be at least 4");
  end
  if (BLANK_UNIT < 1) begin : g_bad_blank_unit
    $error("BLANK_UNIT must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  motor_pkg::gain_t speed_loop_integral_gain;
  motor_pkg::gain_t speed_loop_prop_gain;
  logic [7:0]       startup_blanking_time;
  logic [7:0]       inverse_resistance;
  logic [1:0]       inverse_resistance_scale_sel;
  logic             stall_flag;
  logic             stall_event;
  logic             clr_stall;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      speed_loop_integral_gain     <= `RST_INTEGRAL_GAIN;
      speed_loop_prop_gain         <= `RST_PROP_GAIN;
      startup_blanking_time        <= `RST_BLANKING;
      inverse_resistance           <= `RST_INVERSE_RESISTANCE;
      inverse_resistance_scale_sel <= 2'(`RST_INVERSE_RES_SCALE);
    end else if (i_reg_req.wr) begin
      if (i_reg_req.addr == `OFS_SPEED_LOOP_INTEGRAL_GAIN) begin
        speed_loop_integral_gain <= i_reg_req.wdata;
      end else if (i_reg_req.addr == `OFS_SPEED_LOOP_PROP_GAIN) begin
        speed_loop_prop_gain <= i_reg_req.wdata;
      end else if (i_reg_req.addr == `OFS_STARTUP_BLANKING_TIME) begin
        startup_blanking_time <= i_reg_req.wdata;
      end else if (i_reg_req.addr == `OFS_INVERSE_RESISTANCE) begin
        inverse_resistance <= i_reg_req.wdata; // value is host's to range
      end else if (i_reg_req.addr == `OFS_INVERSE_RES_SCALE) begin
        inverse_resistance_scale_sel <= i_reg_req.wdata[1:0];
      end
    end
  end

  // status: write one to clear, a fresh stall wins over the clear
  assign clr_stall = i_reg_req.wr && (i_reg_req.addr == `OFS_STALL_STATUS) && i_reg_req.wdata[`STALL_BIT];

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      stall_flag <= 1'b0;
    end else if (stall_event) begin
      stall_flag <= 1'b1;
    end else if (clr_stall) begin
      stall_flag <= 1'b0;
    end
  end

  // fault pin from its own flop so decode logic never glitches the pin
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_fault_out_n <= 1'b1;
    end else if (stall_event) begin
      o_fault_out_n <= 1'b0;
    end else if (clr_stall) begin
      o_fault_out_n <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_req.rd) begin
      if (i_reg_req.addr == `OFS_SPEED_LOOP_INTEGRAL_GAIN) begin
        o_reg_rdata <= speed_loop_integral_gain;
      end else if (i_reg_req.addr == `OFS_SPEED_LOOP_PROP_GAIN) begin
        o_reg_rdata <= speed_loop_prop_gain;
      end else if (i_reg_req.addr == `OFS_STARTUP_BLANKING_TIME) begin
        o_reg_rdata <= startup_blanking_time;
      end else if (i_reg_req.addr == `OFS_STALL_STATUS) begin
        o_reg_rdata <= {7'h00, stall_flag};
      end else if (i_reg_req.addr == `OFS_INVERSE_RESISTANCE) begin
        o_reg_rdata <= inverse_resistance;
      end else if (i_reg_req.addr == `OFS_INVERSE_RES_SCALE) begin
        o_reg_rdata <= {6'h00, inverse_resistance_scale_sel};
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PI loop
  logic signed [W+5:0] p_term;
  logic signed [W+5:0] i_step;
  logic signed [W+7:0] integ;
  logic                step_valid;

  gain_term #(.W(W)) u_p_gain (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_en      (i_ctrl_update),
    .i_value   (i_speed_error),
    .i_gain    (speed_loop_prop_gain),
    .o_result  (p_term)
  );

  gain_term #(.W(W)) u_i_gain (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_en      (i_ctrl_update),
    .i_value   (i_speed_error),
    .i_gain    (speed_loop_integral_gain),
    .o_result  (i_step)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      step_valid <= 1'b0;
    end else begin
      step_valid <= i_ctrl_update;
    end
  end

  // integrator wraps rather than saturates; W+8 bits gives ample headroom
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_motor_start) begin
      integ        <= '0;
      o_regulation <= '0;
    end else if (step_valid) begin
      integ        <= integ + (W+8)'(i_step);
      o_regulation <= integ + (W+8)'(i_step) + (W+8)'(p_term);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stall detection
  motor_pkg::stall_state_t state;
  logic [7:0]  blank_units;
  logic [31:0] unit_cnt;
  logic        trip;

  assign trip        = i_use_fixed_3v ? i_sense_over_3v : i_sense_over_ref;
  assign stall_event = (state == motor_pkg::ST_WATCH) && trip;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state       <= motor_pkg::ST_IDLE;
      blank_units <= 8'h00;
      unit_cnt    <= '0;
    end else if (i_motor_start) begin
      state       <= motor_pkg::ST_BLANK;
      blank_units <= startup_blanking_time;
      unit_cnt    <= '0;
    end else begin
      case (state)
        motor_pkg::ST_BLANK: begin
          // a zero count still costs one cycle before watching starts
          if (blank_units == 8'h00) begin
            state <= motor_pkg::ST_WATCH;
          end else if (unit_cnt == 32'(BLANK_UNIT - 1)) begin
            unit_cnt    <= '0;
            blank_units <= blank_units - 8'h01;
          end else begin
            unit_cnt <= unit_cnt + 32'h00000001;
          end
        end
        default: state <= state;
      endcase
    end
  end

  // chopping uses the same trip level; blanking does not mask it
  assign o_current_chop = i_regulation_select_pin && trip;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_motor_start) begin
      o_bridge_disable <= 1'b0;
    end else if (stall_event && !i_stall_response_select_pin) begin
      o_bridge_disable <= 1'b1;
    end
  end

endmodule // motor_speed_loop_and_stall

// ---- design/motor_cfg.svh ----
// offsets, field positions, reset values and timing counts of the speed loop and stall block
`ifndef MOTOR_CFG_SVH
`define MOTOR_CFG_SVH
`define OFS_SPEED_LOOP_INTEGRAL_GAIN 8'h19
`define OFS_SPEED_LOOP_PROP_GAIN     8'h18
`define OFS_STARTUP_BLANKING_TIME    8'h30
`define OFS_STALL_STATUS             8'h31
`define OFS_INVERSE_RESISTANCE       8'h32
`define OFS_INVERSE_RES_SCALE        8'h33
`define RST_INTEGRAL_GAIN            8'h21
`define RST_PROP_GAIN                8'h21
`define RST_BLANKING                 8'h0A
`define RST_INVERSE_RESISTANCE       8'h00
`define RST_INVERSE_RES_SCALE        8'h00
`define DIV_SEL_MSB                  7
`define DIV_SEL_LSB                  5
`define NUM_MSB                      4
`define NUM_LSB                      0
`define BLANK_UNIT_US                10
`define CLK_MHZ                      250
`define BLANK_UNIT_CYC               (`BLANK_UNIT_US * `CLK_MHZ)
`define STALL_BIT                    0
`endif

// ---- design/motor_pkg.sv ----
// types shared by the speed loop and stall block
package motor_pkg;
  typedef struct packed {
    logic [2:0] div_sel;
    logic [4:0] numerator;
  } gain_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BLANK = 3'b010,
    ST_WATCH = 3'b100
  } stall_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ---- design/gain_term.sv ----
// one gain stage: value times numerator divided by the selected divisor
`timescale 1ns/1ps
module gain_term #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  // operand and gain
  input  wire logic                 i_en,
  input  wire logic signed [W-1:0]  i_value,
  input  wire motor_pkg::gain_t     i_gain,
  // result
  output logic signed [W+5:0]       o_result
);
  // refused at elaboration: narrower operands leave no room for the shifted product
  if (W < 4) begin : g_bad_width
    $error("gain_term: W too small");
  end

  function automatic logic [3:0] div_shift(input logic [2:0] sel);
    case (sel)
      3'b000: div_shift = 4'h5;
      3'b001: div_shift = 4'h6;
      3'b010: div_shift = 4'h7;
      3'b011: div_shift = 4'h8;
      3'b100: div_shift = 4'h9;
      3'b101: div_shift = 4'h4;
      3'b110: div_shift = 4'h0;
      default: div_shift = 4'h0; // unlisted code treated as divide by one
    endcase
  endfunction

  logic signed [W+5:0] product;
  assign product = i_value * $signed({1'b0, i_gain.numerator});

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_result <= '0;
    end else if (i_en) begin
      o_result <= product >>> div_shift(i_gain.div_sel);
    end
  end
endmodule // gain_term

// ---- tb/motor_speed_loop_and_stall_properties.sv ----
// port assertions for the speed loop and stall block
`timescale 1ns/1ps
module motor_speed_loop_and_stall_properties #(
  parameter int W          = 16,
  parameter int BLANK_UNIT = 2
) (
  // clock and reset
  input wire logic                i_clk_sys,
  input wire logic                i_srst,
  // register port
  input wire motor_pkg::reg_req_t i_reg_req,
  input wire logic [7:0]          o_reg_rdata,
  // comparators and pins
  input wire logic                i_sense_over_ref,
  input wire logic                i_sense_over_3v,
  input wire logic                i_use_fixed_3v,
  input wire logic                i_stall_response_select_pin,
  input wire logic                i_regulation_select_pin,
  // motor control
  input wire logic                i_motor_start,
  input wire logic                i_ctrl_update,
  input wire logic [W-1:0]        i_speed_error,
  // outputs
  input wire logic                o_fault_out_n,
  input wire logic                o_bridge_disable,
  input wire logic                o_current_chop,
  input wire logic [W+7:0]        o_regulation
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  logic trip;
  logic clr_wr;
  logic unmapped;
  assign trip = i_use_fixed_3v ? i_sense_over_3v : i_sense_over_ref;
  assign clr_wr = i_reg_req.wr && i_reg_req.addr == 8'h31 && i_reg_req.wdata[0];
  assign unmapped = !(i_reg_req.addr inside {8'h18, 8'h19, 8'h30, 8'h31, 8'h32, 8'h33});
  //////////////////////////////
  property p_chop; o_current_chop == (i_regulation_select_pin && trip); endproperty
  a_chop: assert property (p_chop) else $error("chop mismatch");
  property p_fault_set; $fell(o_fault_out_n) |-> $past(trip); endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault without trip");
  property p_fault_clr; $rose(o_fault_out_n) |-> $past(clr_wr); endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault cleared alone");
  property p_rd_hold; !$stable(o_reg_rdata) |-> $past(i_reg_req.rd); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped; i_reg_req.rd && unmapped |=> o_reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_bdis_set; $rose(o_bridge_disable) |-> !o_fault_out_n && !$past(i_stall_response_select_pin); endproperty
  a_bdis_set: assert property (p_bdis_set) else $error("bridge off wrongly");
  property p_bdis_clr; i_motor_start |=> !o_bridge_disable; endproperty
  a_bdis_clr: assert property (p_bdis_clr) else $error("bridge not released");
  property p_reg_time;
    !$stable(o_regulation) |-> $past(i_ctrl_update, 2) || $past(i_motor_start) || $past(i_motor_start, 2);
  endproperty
  a_reg_time: assert property (p_reg_time) else $error("regulation moved");
  cover property ($fell(o_fault_out_n));
  cover property ($rose(o_bridge_disable));
  cover property (i_reg_req.rd && unmapped);
endmodule // motor_speed_loop_and_stall_properties
bind motor_speed_loop_and_stall motor_speed_loop_and_stall_properties #(.W(W), .BLANK_UNIT(BLANK_UNIT)) i_props (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
  .i_sense_over_ref(i_sense_over_ref), .i_sense_over_3v(i_sense_over_3v), .i_use_fixed_3v(i_use_fixed_3v),
  .i_stall_response_select_pin(i_stall_response_select_pin), .i_regulation_select_pin(i_regulation_select_pin),
  .i_motor_start(i_motor_start), .i_ctrl_update(i_ctrl_update), .i_speed_error(i_speed_error),
  .o_fault_out_n(o_fault_out_n), .o_bridge_disable(o_bridge_disable), .o_current_chop(o_current_chop),
  .o_regulation(o_regulation));

// ---- tb/host_model.sv ----
// host side: register accesses toward the device
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic           i_clk_sys,
  // register request
  output motor_pkg::reg_req_t o_reg_req
);
  initial o_reg_req = '0;
  // released lines show the inverse, not the last value
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk_sys);
    o_reg_req <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
    @(posedge i_clk_sys);
    o_reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask
  // largest scale whose rounded quotient fits the field
  task automatic set_inverse_resistance(input int ohms);
    int scale[4];
    int q;
    int s;
    scale = '{2, 64, 1024, 8192};
    s = 4;
    do begin
      s--;
      q = (scale[s] + ohms / 2) / ohms;
    end while (s > 0 && q > 255);
    access(1'b1, 8'h33, 8'(s));
    access(1'b1, 8'h32, 8'(q));
  endtask
endmodule // host_model

// ---- tb/testbench.sv ----
// self-checking bench for the speed loop and stall block
`timescale 1ns/1ps
module testbench;
  localparam int W = 16;
  logic i_clk_sys, i_srst, o_ref, o_3v, use3, rsp, rgp, start, upd, fault_n, bdis, chop, p_rd, u1, u2, u3;
  motor_pkg::reg_req_t req;
  logic [7:0] rdata;
  logic signed [W-1:0] err;
  logic signed [W+7:0] regul;
  logic [23:0] rq[$];
  logic [23:0] gq[$];
  int num_errors, total_checks, kp, ki, e, it, pt;
  int seed = 50197;
  // code 111 is served as divide by one
  int sh[8] = '{5, 6, 7, 8, 9, 4, 0, 0};
  host_model i_host_model (.i_clk_sys(i_clk_sys), .o_reg_req(req));
  motor_speed_loop_and_stall #(.W(W), .BLANK_UNIT(2)) i_motor_speed_loop_and_stall (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_req(req), .o_reg_rdata(rdata), .i_sense_over_ref(o_ref),
    .i_sense_over_3v(o_3v), .i_use_fixed_3v(use3), .i_stall_response_select_pin(rsp),
    .i_regulation_select_pin(rgp), .i_motor_start(start), .i_ctrl_update(upd), .i_speed_error(err),
    .o_fault_out_n(fault_n), .o_bridge_disable(bdis), .o_current_chop(chop), .o_regulation(regul));
  //////////////////////////////
  task automatic chk(input string what, input logic [23:0] x, input logic [23:0] got);
    total_checks++;
    if (got !== x) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, x, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    rq.push_back({16'h0, x});
    i_host_model.access(1'b0, a, 8'h00);
  endtask
  task automatic go();
    @(posedge i_clk_sys);
    start <= 1'b1;
    @(posedge i_clk_sys);
    start <= 1'b0;
  endtask
  task automatic update(input logic [23:0] x);
    @(posedge i_clk_sys);
    err <= 16'(e);
    upd <= 1'b1;
    gq.push_back(x);
    @(posedge i_clk_sys);
    upd <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask
  // results land one edge after a read, two after an update
  always @(posedge i_clk_sys) begin
    p_rd <= req.rd;
    u1 <= upd;
    u2 <= u1;
    u3 <= u2;
  end
  always @(negedge i_clk_sys) begin
    if (p_rd && rq.size() > 0) chk("read data", rq.pop_front(), {16'h0, rdata});
    if (u3 && gq.size() > 0) chk("regulation", gq.pop_front(), regul);
  end
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #20000;
    num_errors++;
    wrap_up();
  end
  initial begin
    {o_ref, o_3v, use3, rsp, rgp, start, upd, p_rd, u1, u2, u3} = '0;
    err = '0;
    i_srst = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    rd(8'h19, 8'h21);
    rd(8'h18, 8'h21);
    rd(8'h40, 8'h00);
    i_host_model.set_inverse_resistance(25);
    rd(8'h33, 8'h02);
    rd(8'h32, 8'h29);
    for (int c = 0; c < 8; c++) begin
      kp = $random(seed) & 31;
      ki = $random(seed) & 31;
      e = $random(seed) % 2000;
      i_host_model.access(1'b1, 8'h18, {3'(c), 5'(kp)});
      i_host_model.access(1'b1, 8'h19, {3'(c), 5'(ki)});
      rd(8'h19, {3'(c), 5'(ki)});
      go();
      it = (e * ki) >>> sh[c];
      pt = (e * kp) >>> sh[c];
      update(24'(it + pt));
      update(24'(2 * it + pt));
    end
    i_host_model.access(1'b1, 8'h30, 8'h02);
    o_ref <= 1'b1;
    rgp <= 1'b1;
    go();
    repeat (2) @(negedge i_clk_sys);
    chk("fault in blanking", 24'h1, {23'h0, fault_n});
    repeat (10) @(negedge i_clk_sys);
    chk("fault", 24'h0, {23'h0, fault_n});
    chk("bridge off", 24'h1, {23'h0, bdis});
    chk("chop", 24'h1, {23'h0, chop});
    rd(8'h31, 8'h01);
    o_ref <= 1'b0;
    i_host_model.access(1'b1, 8'h31, 8'h01);
    rd(8'h31, 8'h00);
    {rsp, use3, o_3v} <= 3'b111;
    go();
    repeat (12) @(negedge i_clk_sys);
    chk("fault fixed level", 24'h0, {23'h0, fault_n});
    chk("bridge report only", 24'h0, {23'h0, bdis});
    @(posedge i_clk_sys);
    rgp <= 1'b0;
    @(negedge i_clk_sys);
    chk("chop disabled", 24'h0, {23'h0, chop});
    wrap_up();
  end
endmodule // testbench
